// *** cfgdec_pkg.sv ***
// cfgdec_pkg: constants, enums and carriers of the configuration word decoder
// assumes a 125 MHz core clock and an AXI4-Lite register master
package cfgdec_pkg;

  // ****************************************
  // configuration word layout
  // ****************************************
  localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;
  localparam logic [13:0] CFG_SPACE_LO = 14'h2000;
  localparam logic [13:0] CFG_SPACE_HI = 14'h3fff;
  localparam logic [13:0] CFG_ERASED = 14'h3fff;
  localparam int UNIMP_BIT = 7;
  localparam int BOR_BIT = 6;
  localparam int PUP_N_BIT = 3;
  localparam int WDT_BIT = 2;
  localparam int CLK_LSB = 0;
  localparam logic [1:0] CP_OFF = 2'h3;
  localparam logic [1:0] CP_UPPER = 2'h2;
  localparam logic [1:0] CP_MID = 2'h1;
  localparam logic [1:0] CP_ALL = 2'h0;
  localparam logic [10:0] GUARD_BASE_1K = 11'h400;
  localparam logic [10:0] GUARD_BASE_HALFK = 11'h200;
  localparam logic [10:0] GUARD_BASE_ZERO = 11'h000;
  localparam logic [10:0] TOP_2K = 11'h7ff;
  localparam logic [10:0] TOP_1K = 11'h3ff;
  localparam logic [10:0] TOP_HALFK = 11'h1ff;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PUP_MS = 72;
  localparam int unsigned PUP_CYCLES = PUP_MS * CLK_MHZ * 1000;
  localparam int unsigned OSU_OSC_CYCLES = 1024;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] REG_PROG_ADDR = 32'h0000_0000;
  localparam logic [31:0] REG_PROG_DATA = 32'h0000_0004;
  localparam logic [31:0] REG_STATUS = 32'h0000_0008;
  localparam logic [31:0] REG_SEQ = 32'h0000_000c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int ST_BOR = 0;
  localparam int ST_PUP = 1;
  localparam int ST_WDT = 2;
  localparam int ST_CLK_LSB = 3;
  localparam int ST_GUARD = 5;
  localparam int ST_BASE_LSB = 16;
  localparam int SQ_STATE_LSB = 0;
  localparam int SQ_RESET = 3;
  localparam int SQ_PROG = 4;
  localparam int SQ_CAUSE_LSB = 5;
  localparam logic [4:0] SYNC_RST = 5'h04;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {SIZE_2K = 2'h0, SIZE_1K = 2'h1, SIZE_HALFK = 2'h2} cfgdec_size_e;
  typedef enum logic [1:0] {
    CLK_LOW_POWER_CRYSTAL = 2'h0,
    CLK_STANDARD_CRYSTAL = 2'h1,
    CLK_HIGH_SPEED_CRYSTAL = 2'h2,
    CLK_RC = 2'h3
  } cfgdec_clk_e;
  typedef enum logic [2:0] {
    SEQ_HOLD = 3'h0,
    SEQ_PUP = 3'h1,
    SEQ_OSU = 3'h3,
    SEQ_RUN = 3'h2,
    SEQ_SLEEP = 3'h6
  } cfgdec_state_e;
  typedef enum logic [1:0] {CAUSE_POR = 2'h0, CAUSE_BOR = 2'h1, CAUSE_OTHER = 2'h2} cfgdec_cause_e;
  typedef struct packed {
    logic borEn;
    logic pupEn;
    logic wdtEn;
    cfgdec_clk_e clkMode;
    logic guardOn;
    logic [10:0] guardBase;
    logic [10:0] guardTop;
  } cfgdec_opt_s;
  localparam cfgdec_opt_s OPT_RST = '{1'b1, 1'b1, 1'b1, CLK_RC, 1'b0, 11'h000, 11'h000};
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } cfgdec_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } cfgdec_axi_rsp_s;

endpackage : cfgdec_pkg

// *** cfgdec_config_word.sv ***
// cfgdec_config_word: configuration word store, option decode, reset sequencer
// assumes pins are asynchronous to clk; sleepReq and wakeIrq come from clk logic
`timescale 1ns/1ns

module cfgdec_config_word #(
  parameter cfgdec_pkg::cfgdec_size_e MEM_SIZE = cfgdec_pkg::SIZE_2K,
  parameter int unsigned PUP_CYCLES = cfgdec_pkg::PUP_CYCLES,
  parameter int unsigned OSU_CYCLES = cfgdec_pkg::OSU_OSC_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire cfgdec_pkg::cfgdec_axi_req_s axiReq,
  output cfgdec_pkg::cfgdec_axi_rsp_s axiRsp,
  // pins
  input wire logic progModePin,
  input wire logic brownoutPin,
  input wire logic mclrPin_b,
  input wire logic watchdogTimeout,
  input wire logic clockInputPin,
  // core
  input wire logic sleepReq,
  input wire logic wakeIrq,
  // decoded options and reset state
  output cfgdec_pkg::cfgdec_opt_s opt,
  output logic crystalMode,
  output logic watchdogOscRun,
  output logic deviceReset,
  output logic sleeping
);

  localparam int PW = $clog2(PUP_CYCLES + 1);
  localparam int OW = $clog2(OSU_CYCLES + 1);
  localparam logic [PW-1:0] PUP_LAST = PW'(PUP_CYCLES - 1);
  localparam logic [OW-1:0] OSU_LAST = OW'(OSU_CYCLES - 1);

  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic clkIn_q;
  logic clkRise;
  logic progMode;
  logic mclr;
  logic borTrip;
  logic wdtTo;
  logic resetReq;
  logic [13:0] cfgWord_q;
  logic [13:0] progAddr_q;
  logic [1:0] cpAll;
  cfgdec_pkg::cfgdec_opt_s liveOpt;
  cfgdec_pkg::cfgdec_opt_s opt_q;
  cfgdec_pkg::cfgdec_state_e state_q;
  cfgdec_pkg::cfgdec_state_e state_d;
  cfgdec_pkg::cfgdec_cause_e cause_q;
  logic [PW-1:0] pupCnt_q;
  logic [OW-1:0] osuCnt_q;
  logic pupDone;
  logic osuDone;
  logic awFire;
  logic arFire;
  logic [1:0] wResp;
  logic [1:0] rResp;
  logic [31:0] rData;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic rdCfg_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= cfgdec_pkg::SYNC_RST;
      sync_q <= cfgdec_pkg::SYNC_RST;
    end
    else
    begin
      meta_q <= {clockInputPin, watchdogTimeout, mclrPin_b, brownoutPin, progModePin};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      clkIn_q <= 1'b0;
    else
      clkIn_q <= sync_q[4];
  end

  // crystal or external clock both arrive as edges here
  assign clkRise = sync_q[4] & ~clkIn_q;
  assign progMode = sync_q[0];
  assign mclr = ~sync_q[2];
  assign borTrip = sync_q[1] & (state_q == cfgdec_pkg::SEQ_HOLD ? liveOpt.borEn : opt_q.borEn);
  assign wdtTo = sync_q[3] & opt_q.wdtEn;
  assign resetReq = progMode | mclr | borTrip;

  // ****************************************
  // option decode
  // ****************************************
  always_comb
  begin
    cpAll = cfgWord_q[13:12] & cfgWord_q[11:10] & cfgWord_q[9:8] & cfgWord_q[5:4];
    liveOpt.borEn = cfgWord_q[cfgdec_pkg::BOR_BIT];
    liveOpt.pupEn = ~cfgWord_q[cfgdec_pkg::PUP_N_BIT] | cfgWord_q[cfgdec_pkg::BOR_BIT];
    liveOpt.wdtEn = cfgWord_q[cfgdec_pkg::WDT_BIT];
    liveOpt.clkMode = cfgdec_pkg::cfgdec_clk_e'(cfgWord_q[cfgdec_pkg::CLK_LSB +: 2]);
    liveOpt.guardOn = 1'b0;
    liveOpt.guardBase = cfgdec_pkg::GUARD_BASE_ZERO;
    liveOpt.guardTop = cfgdec_pkg::TOP_2K;
    unique case (MEM_SIZE)
      cfgdec_pkg::SIZE_2K:
      begin
        liveOpt.guardOn = cpAll != cfgdec_pkg::CP_OFF;
        if (cpAll == cfgdec_pkg::CP_UPPER)
          liveOpt.guardBase = cfgdec_pkg::GUARD_BASE_1K;
        else if (cpAll == cfgdec_pkg::CP_MID)
          liveOpt.guardBase = cfgdec_pkg::GUARD_BASE_HALFK;
      end
      cfgdec_pkg::SIZE_1K:
      begin
        liveOpt.guardTop = cfgdec_pkg::TOP_1K;
        liveOpt.guardOn = cpAll == cfgdec_pkg::CP_MID || cpAll == cfgdec_pkg::CP_ALL;
        if (cpAll == cfgdec_pkg::CP_MID)
          liveOpt.guardBase = cfgdec_pkg::GUARD_BASE_HALFK;
      end
      default:
      begin
        liveOpt.guardTop = cfgdec_pkg::TOP_HALFK;
        liveOpt.guardOn = cpAll == cfgdec_pkg::CP_ALL;
      end
    endcase
  end

  // options follow the word only while the sequencer sits in SEQ_HOLD
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      opt_q <= cfgdec_pkg::OPT_RST;
    else if (state_q == cfgdec_pkg::SEQ_HOLD)
      opt_q <= liveOpt;
  end

  assign opt = opt_q;
  assign crystalMode = opt_q.clkMode != cfgdec_pkg::CLK_RC;
  assign watchdogOscRun = opt_q.wdtEn;
  assign deviceReset = state_q != cfgdec_pkg::SEQ_RUN && state_q != cfgdec_pkg::SEQ_SLEEP;
  assign sleeping = state_q == cfgdec_pkg::SEQ_SLEEP;

  // ****************************************
  // reset sequencer
  // ****************************************
  assign pupDone = pupCnt_q == PUP_LAST;
  assign osuDone = clkRise && osuCnt_q == OSU_LAST;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      cfgdec_pkg::SEQ_HOLD:
      begin
        if (!resetReq)
        begin
          if (cause_q != cfgdec_pkg::CAUSE_OTHER && liveOpt.pupEn)
            state_d = cfgdec_pkg::SEQ_PUP;
          else if (cause_q == cfgdec_pkg::CAUSE_POR && liveOpt.clkMode != cfgdec_pkg::CLK_RC)
            state_d = cfgdec_pkg::SEQ_OSU;
          else
            state_d = cfgdec_pkg::SEQ_RUN;
        end
      end
      cfgdec_pkg::SEQ_PUP:
      begin
        if (resetReq)
          state_d = cfgdec_pkg::SEQ_HOLD;
        else if (pupDone && cause_q == cfgdec_pkg::CAUSE_POR && opt_q.clkMode != cfgdec_pkg::CLK_RC)
          state_d = cfgdec_pkg::SEQ_OSU;
        else if (pupDone)
          state_d = cfgdec_pkg::SEQ_RUN;
      end
      cfgdec_pkg::SEQ_OSU:
      begin
        if (resetReq)
          state_d = cfgdec_pkg::SEQ_HOLD;
        else if (osuDone)
          state_d = cfgdec_pkg::SEQ_RUN;
      end
      cfgdec_pkg::SEQ_RUN:
      begin
        if (resetReq || wdtTo)
          state_d = cfgdec_pkg::SEQ_HOLD;
        else if (sleepReq)
          state_d = cfgdec_pkg::SEQ_SLEEP;
      end
      cfgdec_pkg::SEQ_SLEEP:
      begin
        if (resetReq)
          state_d = cfgdec_pkg::SEQ_HOLD;
        else if ((wdtTo || wakeIrq) && opt_q.clkMode != cfgdec_pkg::CLK_RC)
          state_d = cfgdec_pkg::SEQ_OSU;
        else if (wdtTo || wakeIrq)
          state_d = cfgdec_pkg::SEQ_RUN;
      end
      default:
        state_d = cfgdec_pkg::SEQ_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= cfgdec_pkg::SEQ_HOLD;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cause_q <= cfgdec_pkg::CAUSE_POR;
    else if (borTrip)
      cause_q <= cfgdec_pkg::CAUSE_BOR;
    else if (state_q != cfgdec_pkg::SEQ_HOLD && state_d == cfgdec_pkg::SEQ_HOLD)
      cause_q <= cfgdec_pkg::CAUSE_OTHER;
  end

  // a reset request or leaving the timer state clears the count, so a re-entry restarts it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pupCnt_q <= '0;
    else if (state_q == cfgdec_pkg::SEQ_PUP && !pupDone && !resetReq)
      pupCnt_q <= pupCnt_q + PW'(1);
    else
      pupCnt_q <= '0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      osuCnt_q <= '0;
    else if (state_q != cfgdec_pkg::SEQ_OSU)
      osuCnt_q <= '0;
    else if (clkRise)
      osuCnt_q <= osuCnt_q + OW'(1);
  end

  // ****************************************
  // register bus
  // ****************************************
  assign awFire = axiReq.awvalid & axiReq.wvalid & ~bvalid_q;
  assign arFire = axiReq.arvalid & ~rvalid_q;

  always_comb
  begin
    wResp = cfgdec_pkg::RESP_OKAY;
    unique case (axiReq.awaddr)
      cfgdec_pkg::REG_PROG_ADDR, cfgdec_pkg::REG_STATUS, cfgdec_pkg::REG_SEQ:
        wResp = cfgdec_pkg::RESP_OKAY;
      cfgdec_pkg::REG_PROG_DATA:
        wResp = progMode ? cfgdec_pkg::RESP_OKAY : cfgdec_pkg::RESP_SLVERR;
      default:
        wResp = cfgdec_pkg::RESP_DECERR;
    endcase
  end

  always_comb
  begin
    rResp = cfgdec_pkg::RESP_OKAY;
    rData = '0;
    unique case (axiReq.araddr)
      cfgdec_pkg::REG_PROG_ADDR:
        rData[13:0] = progAddr_q;
      cfgdec_pkg::REG_PROG_DATA:
      begin
        if (!progMode)
          rResp = cfgdec_pkg::RESP_SLVERR;
        else if (progAddr_q == cfgdec_pkg::CFG_WORD_ADDR)
        begin
          rData[13:0] = cfgWord_q;
          rData[cfgdec_pkg::UNIMP_BIT] = 1'b0;
        end
      end
      cfgdec_pkg::REG_STATUS:
      begin
        rData[cfgdec_pkg::ST_BOR] = opt_q.borEn;
        rData[cfgdec_pkg::ST_PUP] = opt_q.pupEn;
        rData[cfgdec_pkg::ST_WDT] = opt_q.wdtEn;
        rData[cfgdec_pkg::ST_CLK_LSB +: 2] = opt_q.clkMode;
        rData[cfgdec_pkg::ST_GUARD] = opt_q.guardOn;
        rData[cfgdec_pkg::ST_BASE_LSB +: 11] = opt_q.guardBase;
      end
      cfgdec_pkg::REG_SEQ:
      begin
        rData[cfgdec_pkg::SQ_STATE_LSB +: 3] = state_q;
        rData[cfgdec_pkg::SQ_RESET] = deviceReset;
        rData[cfgdec_pkg::SQ_PROG] = progMode;
        rData[cfgdec_pkg::SQ_CAUSE_LSB +: 2] = cause_q;
      end
      default:
        rResp = cfgdec_pkg::RESP_DECERR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      progAddr_q <= '0;
    else if (awFire && axiReq.awaddr == cfgdec_pkg::REG_PROG_ADDR)
    begin
      if (axiReq.wstrb[0])
        progAddr_q[7:0] <= axiReq.wdata[7:0];
      if (axiReq.wstrb[1])
        progAddr_q[13:8] <= axiReq.wdata[13:8];
    end
  end

  // only the word at the configuration address is stored; other test space ignores writes
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cfgWord_q <= cfgdec_pkg::CFG_ERASED;
    else if (awFire && axiReq.awaddr == cfgdec_pkg::REG_PROG_DATA && progMode
             && progAddr_q == cfgdec_pkg::CFG_WORD_ADDR)
    begin
      if (axiReq.wstrb[0])
        cfgWord_q[7:0] <= axiReq.wdata[7:0];
      if (axiReq.wstrb[1])
        cfgWord_q[13:8] <= axiReq.wdata[13:8];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= cfgdec_pkg::RESP_OKAY;
    end
    else if (awFire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wResp;
    end
    else if (axiReq.bready)
      bvalid_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= cfgdec_pkg::RESP_OKAY;
      rdata_q <= '0;
      rdCfg_q <= 1'b0;
    end
    else if (arFire)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= rResp;
      rdata_q <= rData;
      rdCfg_q <= axiReq.araddr == cfgdec_pkg::REG_PROG_DATA;
    end
    else if (axiReq.rready)
      rvalid_q <= 1'b0;
  end

  assign axiRsp.awready = awFire;
  assign axiRsp.wready = awFire;
  assign axiRsp.bvalid = bvalid_q;
  assign axiRsp.bresp = bresp_q;
  assign axiRsp.arready = ~rvalid_q;
  assign axiRsp.rvalid = rvalid_q;
  assign axiRsp.rresp = rresp_q;
  assign axiRsp.rdata = rdata_q;

  // ****************************************
  // assertions
  // ****************************************
  property p_prog_only;
    awFire && axiReq.awaddr == cfgdec_pkg::REG_PROG_DATA && !progMode
      |=> bvalid_q && bresp_q == cfgdec_pkg::RESP_SLVERR && $stable(cfgWord_q);
  endproperty
  a_prog_only: assert property (p_prog_only) else $error("config write outside programming mode");

  property p_cfg_addr;
    awFire && axiReq.awaddr == cfgdec_pkg::REG_PROG_DATA && progAddr_q != cfgdec_pkg::CFG_WORD_ADDR
      |=> $stable(cfgWord_q);
  endproperty
  a_cfg_addr: assert property (p_cfg_addr) else $error("word stored at wrong address");

  property p_bit7_zero;
    rvalid_q && rdCfg_q |-> !rdata_q[cfgdec_pkg::UNIMP_BIT];
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("unimplemented bit read as one");

  property p_guard_2k;
    MEM_SIZE == cfgdec_pkg::SIZE_2K && state_q == cfgdec_pkg::SEQ_HOLD && cpAll == cfgdec_pkg::CP_UPPER
      |=> opt_q.guardOn && opt_q.guardBase == cfgdec_pkg::GUARD_BASE_1K;
  endproperty
  a_guard_2k: assert property (p_guard_2k) else $error("2K upper guard wrong");

  property p_guard_1k;
    MEM_SIZE == cfgdec_pkg::SIZE_1K && state_q == cfgdec_pkg::SEQ_HOLD && cpAll[1] |=> !opt_q.guardOn;
  endproperty
  a_guard_1k: assert property (p_guard_1k) else $error("1K guard on for 11 or 10");

  property p_guard_halfk;
    MEM_SIZE == cfgdec_pkg::SIZE_HALFK && state_q == cfgdec_pkg::SEQ_HOLD
      |=> opt_q.guardOn == ($past(cpAll) == cfgdec_pkg::CP_ALL);
  endproperty
  a_guard_halfk: assert property (p_guard_halfk) else $error("half-K guard wrong");

  property p_bor_trip;
    state_q == cfgdec_pkg::SEQ_RUN && sync_q[1] && opt_q.borEn |=> state_q == cfgdec_pkg::SEQ_HOLD;
  endproperty
  a_bor_trip: assert property (p_bor_trip) else $error("brown-out did not reset");

  property p_pup_forced;
    state_q == cfgdec_pkg::SEQ_HOLD && cfgWord_q[cfgdec_pkg::BOR_BIT] |=> opt_q.pupEn;
  endproperty
  a_pup_forced: assert property (p_pup_forced) else $error("timer not forced by brown-out enable");

  property p_pup_pol;
    state_q == cfgdec_pkg::SEQ_HOLD && !cfgWord_q[cfgdec_pkg::PUP_N_BIT] |=> opt_q.pupEn;
  endproperty
  a_pup_pol: assert property (p_pup_pol) else $error("power-up timer polarity wrong");

  property p_wdt_reset;
    state_q == cfgdec_pkg::SEQ_RUN && sync_q[3] && opt_q.wdtEn |=> state_q == cfgdec_pkg::SEQ_HOLD;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog timeout ignored");

  property p_pup_len;
    state_q == cfgdec_pkg::SEQ_PUP && !pupDone && !resetReq |=> state_q == cfgdec_pkg::SEQ_PUP;
  endproperty
  a_pup_len: assert property (p_pup_len) else $error("power-up timer ended early");

  property p_bor_restart;
    state_q == cfgdec_pkg::SEQ_PUP && borTrip |=> state_q == cfgdec_pkg::SEQ_HOLD && pupCnt_q == '0;
  endproperty
  a_bor_restart: assert property (p_bor_restart) else $error("timer not restarted");

  property p_osu_edges;
    state_q == cfgdec_pkg::SEQ_OSU && !clkRise && !resetReq |=> state_q == cfgdec_pkg::SEQ_OSU && $stable(osuCnt_q);
  endproperty
  a_osu_edges: assert property (p_osu_edges) else $error("start-up timer moved without edge");

  property p_sleep_wake;
    state_q == cfgdec_pkg::SEQ_SLEEP && wakeIrq && !resetReq |=> !deviceReset || state_q == cfgdec_pkg::SEQ_OSU;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("interrupt did not wake");

  property p_opts_held;
    state_q != cfgdec_pkg::SEQ_HOLD |=> $stable(opt_q);
  endproperty
  a_opts_held: assert property (p_opts_held) else $error("options changed while running");

endmodule : cfgdec_config_word

// *** cfgdec_prog_model.sv ***
// cfgdec_prog_model: programmer writing the configuration word over the bus
// assumes the decoder answers every transfer as its bus contract says
`timescale 1ns/1ns
module cfgdec_prog_model (
  // clock
  input wire logic clk,
  // register bus
  output cfgdec_pkg::cfgdec_axi_req_s req,
  input wire cfgdec_pkg::cfgdec_axi_rsp_s rsp,
  // programming pin
  output logic progMode
);
  initial
  begin
    req = '0;
    req.wstrb = 4'hf;
    progMode = 1'b0;
  end

  // one transfer; ok drops if the answer never comes
  task automatic xfer(input bit wr, input logic [31:0] a, input logic [31:0] d, output bit ok);
    int n = 0;
    @(posedge clk);
    if (wr)
    begin
      req.awaddr <= a;
      req.wdata <= d;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
    end
    else
    begin
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
    end
    do @(posedge clk); while ((wr ? rsp.awready : rsp.arready) !== 1'b1 && ++n < 99);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    req.arvalid <= 1'b0;
    do @(posedge clk); while ((wr ? rsp.bvalid : rsp.rvalid) !== 1'b1 && ++n < 99);
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    ok = n < 99;
  endtask : xfer

  task automatic prog(input logic [1:0] cp, input logic [5:0] f, output bit ok);
    bit ok2;
    @(posedge clk);
    progMode <= 1'b1;
    repeat (4) @(posedge clk);
    xfer(1'b1, cfgdec_pkg::REG_PROG_ADDR, 32'(cfgdec_pkg::CFG_WORD_ADDR), ok);
    xfer(1'b1, cfgdec_pkg::REG_PROG_DATA, 32'({cp, cp, cp, f[5:4], cp, f[3:0]}), ok2);
    ok = ok & ok2;
  endtask : prog

  task automatic leave();
    @(posedge clk);
    progMode <= 1'b0;
  endtask : leave
endmodule : cfgdec_prog_model

// *** cfgdec_config_word_tb_top.sv ***
// cfgdec_config_word_tb_top: self-checking bench of the config word decoder
// assumes cfgdec_prog_model masters the register bus
`timescale 1ns/1ns
module cfgdec_config_word_tb_top;
  localparam int unsigned PW = 20;
  localparam logic [1:0] OK = cfgdec_pkg::RESP_OKAY;
  localparam logic [31:0] DAT = cfgdec_pkg::REG_PROG_DATA;
  localparam logic [31:0] STA = cfgdec_pkg::REG_STATUS;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic brownoutPin = 1'b0;
  logic mclrPin_b = 1'b1;
  logic wdtTo = 1'b0;
  logic sleepReq = 1'b0;
  logic wakeIrq = 1'b0;
  logic [1:0] osc = 2'h0;
  logic progModePin, crystalMode, watchdogOscRun, deviceReset, sleeping;
  cfgdec_pkg::cfgdec_axi_req_s axiReq;
  cfgdec_pkg::cfgdec_axi_rsp_s axiRsp;
  cfgdec_pkg::cfgdec_opt_s opt;
  cfgdec_pkg::cfgdec_opt_s opt1k, optHalf;
  logic [33:0] rdQ[$];
  logic [1:0] wrQ[$];
  logic [31:0] seed = 32'h0001_47dd;
  logic [13:0] w;
  int n_fail = 0;
  int checks_done = 0;
  int nRst = 0;
  int n;

  initial forever #4 clk = ~clk;
  // free-running external clock on the oscillator input
  always @(posedge clk) osc <= osc + 2'h1;
  always @(posedge deviceReset) nRst++;

  cfgdec_config_word #(.MEM_SIZE(cfgdec_pkg::SIZE_2K), .PUP_CYCLES(PW), .OSU_CYCLES(4)) u_dut (
    .clk(clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp), .progModePin(progModePin),
    .brownoutPin(brownoutPin), .mclrPin_b(mclrPin_b), .watchdogTimeout(wdtTo), .clockInputPin(osc[1]),
    .sleepReq(sleepReq), .wakeIrq(wakeIrq), .opt(opt), .crystalMode(crystalMode),
    .watchdogOscRun(watchdogOscRun), .deviceReset(deviceReset), .sleeping(sleeping));
  // smaller parts listen to the same bus; only their decoded options are compared
  cfgdec_config_word #(.MEM_SIZE(cfgdec_pkg::SIZE_1K), .PUP_CYCLES(PW), .OSU_CYCLES(4)) u_dut1k (
    .clk(clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(), .progModePin(progModePin),
    .brownoutPin(brownoutPin), .mclrPin_b(mclrPin_b), .watchdogTimeout(wdtTo), .clockInputPin(osc[1]),
    .sleepReq(sleepReq), .wakeIrq(wakeIrq), .opt(opt1k), .crystalMode(),
    .watchdogOscRun(), .deviceReset(), .sleeping());
  cfgdec_config_word #(.MEM_SIZE(cfgdec_pkg::SIZE_HALFK), .PUP_CYCLES(PW), .OSU_CYCLES(4)) u_dutHalf (
    .clk(clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(), .progModePin(progModePin),
    .brownoutPin(brownoutPin), .mclrPin_b(mclrPin_b), .watchdogTimeout(wdtTo), .clockInputPin(osc[1]),
    .sleepReq(sleepReq), .wakeIrq(wakeIrq), .opt(optHalf), .crystalMode(),
    .watchdogOscRun(), .deviceReset(), .sleeping());
  cfgdec_prog_model u_prog (.clk(clk), .req(axiReq), .rsp(axiRsp), .progMode(progModePin));

  // ****
  // helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] stat(input logic [13:0] v);
    logic [1:0] cp;
    logic [10:0] b;
    cp = v[13:12] & v[11:10] & v[9:8] & v[5:4];
    b = (cp == 2'h2) ? 11'h400 : (cp == 2'h1) ? 11'h200 : 11'h000;
    return {5'h00, b, 10'h000, cp != 2'h3, v[1:0], v[2], ~v[3] | v[6], v[6]};
  endfunction : stat

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic guard(input bit ok);
    if (!ok)
    begin
      check(34'h0, 34'h1);
      end_of_test();
    end
  endtask : guard

  task automatic bw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ok;
    wrQ.push_back(r);
    u_prog.xfer(1'b1, a, d, ok);
    guard(ok);
  endtask : bw

  task automatic br(input logic [31:0] a, input logic [33:0] e);
    bit ok;
    rdQ.push_back(e);
    u_prog.xfer(1'b0, a, 32'h0, ok);
    guard(ok);
  endtask : br

  task automatic runw();
    n = 0;
    do @(negedge clk); while (deviceReset !== 1'b0 && ++n < 3000);
    guard(n < 3000);
  endtask : runw

  task automatic prog(input logic [1:0] cp, input logic [5:0] f);
    bit ok;
    w = {cp, cp, cp, f[5:4], cp, f[3:0]};
    wrQ.push_back(OK);
    wrQ.push_back(OK);
    u_prog.prog(cp, f, ok);
    guard(ok);
    br(DAT, {OK, 18'h0, w & 14'h3f7f});
    u_prog.leave();
    runw();
  endtask : prog

  // results checked in arrival order
  always @(posedge clk)
  begin
    if (axiRsp.rvalid === 1'b1 && axiReq.rready === 1'b1 && rdQ.size() > 0)
      check({axiRsp.rresp, axiRsp.rdata}, rdQ.pop_front());
    if (axiRsp.bvalid === 1'b1 && axiReq.bready === 1'b1 && wrQ.size() > 0)
      check(34'(axiRsp.bresp), 34'(wrQ.pop_front()));
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    guard(1'b0);
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    runw();
    check(34'(n >= PW && n <= PW + 8), 34'h1);
    br(STA, {OK, 32'h0000_001f});
    bw(DAT, 32'h0, cfgdec_pkg::RESP_SLVERR);
    br(DAT, {cfgdec_pkg::RESP_SLVERR, 32'h0});
    br(32'h0000_0010, {cfgdec_pkg::RESP_DECERR, 32'h0});
    $display("test bus done");
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      prog(2'(3 - i), {seed[3:0], 2'(i)});
      br(STA, {OK, stat(w)});
      check(34'(crystalMode), 34'(w[1:0] != 2'h3));
      check(34'(watchdogOscRun), 34'(w[2]));
      check(34'(opt.guardTop), 34'h7ff);
      check(34'({opt1k.guardOn, opt1k.guardBase, opt1k.guardTop}), 34'({i >= 2, (i == 2) ? 11'h200 : 11'h000, 11'h3ff}));
      check(34'({optHalf.guardOn, optHalf.guardBase, optHalf.guardTop}), 34'({i == 3, 11'h000, 11'h1ff}));
    end
    $display("test decode done");
    prog(2'h3, 6'h1d);
    @(posedge clk) brownoutPin <= 1'b1;
    repeat (4) @(posedge clk);
    br(cfgdec_pkg::REG_SEQ, {OK, 32'h0000_0028});
    brownoutPin <= 1'b0;
    repeat (8) @(posedge clk);
    brownoutPin <= 1'b1;
    repeat (4) @(posedge clk);
    brownoutPin <= 1'b0;
    runw();
    check(34'(n >= PW && n <= PW + 8), 34'h1);
    $display("test brownout done");
    @(posedge clk) sleepReq <= 1'b1;
    @(posedge clk) sleepReq <= 1'b0;
    @(negedge clk) check(34'(sleeping), 34'h1);
    @(posedge clk) wakeIrq <= 1'b1;
    @(posedge clk) wakeIrq <= 1'b0;
    @(negedge clk) check(34'({sleeping, deviceReset}), 34'h1);
    runw();
    check(34'(n >= 12 && n <= 20), 34'h1);
    n = nRst;
    @(posedge clk) wdtTo <= 1'b1;
    repeat (3) @(posedge clk);
    wdtTo <= 1'b0;
    repeat (4) @(posedge clk);
    check(34'(nRst > n), 34'h1);
    runw();
    @(posedge clk) mclrPin_b <= 1'b0;
    repeat (3) @(posedge clk);
    mclrPin_b <= 1'b1;
    runw();
    check(34'(n < PW), 34'h1);
    br(STA, {OK, stat(w)});
    $display("test reset done");
    end_of_test();
  end
endmodule : cfgdec_config_word_tb_top
